// File: hdl/frd_alu.sv
`timescale 1ns/1ps
`default_nettype none

module frd_alu (
    input wire logic [13:0] instr,
    input wire logic [7:0] operand,
    input wire logic [7:0] acc,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_nxt,
    output logic to_file,
    output logic to_acc
);

    wire logic [1:0] cls = instr[frd_pkg::CLS_HI:frd_pkg::CLS_LO];
    wire logic [3:0] op = instr[frd_pkg::OP_HI:frd_pkg::OP_LO];
    wire logic [1:0] bop = instr[frd_pkg::BOP_HI:frd_pkg::BOP_LO];
    wire logic dsel = instr[frd_pkg::DSEL_BIT];
    wire logic [7:0] mask = frd_pkg::bit_mask(instr[frd_pkg::BSEL_HI:frd_pkg::BSEL_LO]);
    wire logic [8:0] sum = {1'b0, operand} + {1'b0, acc};

    logic routed;

    always_comb
    begin
        result = operand;
        carry_nxt = carry_in;
        routed = 1'b0;
        to_file = 1'b0;
        to_acc = 1'b0;
        if (cls == frd_pkg::CLS_BYTE)
        begin
            case (op)
                frd_pkg::OP_STORE_W:
                begin
                    // The destination bit is a don't-care here.
                    result = acc;
                    to_file = 1'b1;
                end
                frd_pkg::OP_CLEAR:
                begin
                    result = 8'h00;
                    routed = 1'b1;
                end
                frd_pkg::OP_MOVE: routed = 1'b1;
                frd_pkg::OP_ROT_LEFT:
                begin
                    {carry_nxt, result} = {operand, carry_in};
                    routed = 1'b1;
                end
                frd_pkg::OP_ROT_RIGHT:
                begin
                    {result, carry_nxt} = {carry_in, operand};
                    routed = 1'b1;
                end
                frd_pkg::OP_INCR:
                begin
                    result = operand + 8'h01;
                    routed = 1'b1;
                end
                frd_pkg::OP_DECR:
                begin
                    result = operand - 8'h01;
                    routed = 1'b1;
                end
                frd_pkg::OP_COMPL:
                begin
                    result = ~operand;
                    routed = 1'b1;
                end
                frd_pkg::OP_AND_W:
                begin
                    result = operand & acc;
                    routed = 1'b1;
                end
                frd_pkg::OP_OR_W:
                begin
                    result = operand | acc;
                    routed = 1'b1;
                end
                frd_pkg::OP_XOR_W:
                begin
                    result = operand ^ acc;
                    routed = 1'b1;
                end
                frd_pkg::OP_ADD_W:
                begin
                    {carry_nxt, result} = sum;
                    routed = 1'b1;
                end
                default: routed = 1'b0;
            endcase
            to_file = to_file | (routed & dsel);
            to_acc = routed & ~dsel;
        end
        else if (cls == frd_pkg::CLS_BIT)
        begin
            if (bop == frd_pkg::BOP_CLR)
            begin
                result = operand & ~mask;
                to_file = 1'b1;
            end
            else if (bop == frd_pkg::BOP_SET)
            begin
                result = operand | mask;
                to_file = 1'b1;
            end
        end
    end

endmodule : frd_alu

`default_nettype wire

// File: hdl/frd_datapath.sv
// Behaviour
// - Every instruction naming a file register reads it, modifies the value, then writes back.
// - That read carries all side effects of a normal read, so clearing a port may clear a change flag.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - The file address field is seven bits wide and reaches registers 0x00 to 0x7F.
// - The bit select field of bit instructions picks one bit of the addressed byte.
// - Don't-care instruction bits have no effect on execution whatever their value.
// - Rotate left through carry shifts the register left via carry and updates only carry.
// - Rotate left through carry is one word long and finishes in one instruction cycle.
// - Every instruction is a 14-bit word of opcode and operand fields.
// - One instruction cycle is four clock periods and every instruction here takes one cycle.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module frd_datapath (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    output logic instr_take,
    output logic [6:0] file_addr,
    output logic file_rd_en,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    output logic [7:0] acc_out,
    output logic carry_out,
    output logic cycle_done,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    frd_pkg::frd_phase_e phase_r;
    frd_pkg::frd_phase_e phase_nxt;
    logic [13:0] instr_r;
    logic [6:0] file_addr_r;
    logic file_rd_en_r;
    logic file_wr_en_r;
    logic [7:0] file_wr_data_r;
    logic [7:0] acc_r;
    logic carry_r;
    logic instr_take_r;
    logic cycle_done_r;
    logic [7:0] last_res_r;
    logic [7:0] retired_r;
    logic [7:0] reg_rdata_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic take_now = (phase_r == frd_pkg::FRD_Q1) & instr_valid;
    wire logic exec_now = (phase_r == frd_pkg::FRD_Q3);
    wire logic reads_file = frd_pkg::names_file(instr_word);
    wire logic [6:0] faddr_field = instr_word[frd_pkg::FADDR_HI:frd_pkg::FADDR_LO];
    wire logic [13:0] instr_sel = instr_valid ? instr_word : frd_pkg::INSTR_IDLE;

    wire logic [7:0] alu_res;
    wire logic alu_carry;
    wire logic alu_to_file;
    wire logic alu_to_acc;

    // An instruction that names no file register sees a zero operand, so a stale
    // read bus can never leak into the result.
    wire logic [7:0] operand = frd_pkg::names_file(instr_r) ? file_rd_data : 8'h00;

    frd_alu u_alu (
        .instr(instr_r),
        .operand(operand),
        .acc(acc_r),
        .carry_in(carry_r),
        .result(alu_res),
        .carry_nxt(alu_carry),
        .to_file(alu_to_file),
        .to_acc(alu_to_acc)
    );

    // Core writes land only on the Q3 edge, once the partner has answered the
    // read strobe issued in Q2.
    wire logic core_acc_we = exec_now & alu_to_acc;
    wire logic core_file_we = exec_now & alu_to_file;
    wire logic sw_acc_we = reg_wr & (reg_addr == frd_pkg::REG_ACC);
    wire logic sw_flag_we = reg_wr & (reg_addr == frd_pkg::REG_FLAGS);

    wire logic [7:0] acc_nxt = core_acc_we ? alu_res : (sw_acc_we ? reg_wdata : acc_r);
    wire logic sw_carry = reg_wdata[frd_pkg::FLAG_CARRY];
    // Carry is the only flag this datapath owns; other opcodes pass it through.
    wire logic carry_nxt = exec_now ? alu_carry : (sw_flag_we ? sw_carry : carry_r);

    // Unmapped port addresses read as zero and ignore writes, so software probing
    // the map cannot disturb the core.
    wire logic [7:0] rd_mux =
        (reg_addr == frd_pkg::REG_ACC) ? acc_r :
        (reg_addr == frd_pkg::REG_FLAGS) ? {7'h00, carry_r} :
        (reg_addr == frd_pkg::REG_RESULT) ? last_res_r :
        (reg_addr == frd_pkg::REG_RETIRED) ? retired_r : 8'h00;

    // ----------------------------------------------------------------
    // Instruction cycle sequencer
    // ----------------------------------------------------------------
    // Gray coding moves a single bit per phase step.
    always_comb
    begin
        case (phase_r)
            frd_pkg::FRD_Q1: phase_nxt = frd_pkg::FRD_Q2;
            frd_pkg::FRD_Q2: phase_nxt = frd_pkg::FRD_Q3;
            frd_pkg::FRD_Q3: phase_nxt = frd_pkg::FRD_Q4;
            default: phase_nxt = frd_pkg::FRD_Q1;
        endcase
    end

    // The phase counter runs free, so every instruction, the rotate included,
    // occupies exactly four clock periods.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            phase_r <= frd_pkg::FRD_Q1;
        else
            phase_r <= phase_nxt;
    end

    // ----------------------------------------------------------------
    // Fetch and file read
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            instr_r <= frd_pkg::INSTR_IDLE;
            file_addr_r <= 7'h00;
            file_rd_en_r <= 1'b0;
            instr_take_r <= 1'b0;
        end
        else if (phase_r == frd_pkg::FRD_Q1)
        begin
            instr_r <= instr_sel;
            instr_take_r <= instr_valid;
            // The address is latched on every Q1 edge, idle cycles included; it matters
            // only when a read or write strobe goes with it.
            file_addr_r <= faddr_field;
            // A real read strobe even for clear and store, so the partner applies
            // every read side effect before the write-back lands.
            file_rd_en_r <= take_now & reads_file;
        end
        else
        begin
            file_rd_en_r <= 1'b0;
            instr_take_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Execute and write back
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            file_wr_en_r <= 1'b0;
            file_wr_data_r <= 8'h00;
            cycle_done_r <= 1'b0;
            last_res_r <= 8'h00;
            retired_r <= 8'h00;
        end
        else if (exec_now)
        begin
            file_wr_en_r <= core_file_we;
            file_wr_data_r <= alu_res;
            cycle_done_r <= 1'b1;
            last_res_r <= alu_res;
            // Idle cycles retire a no-op too, so this counts elapsed instruction cycles.
            retired_r <= retired_r + 8'h01;
        end
        else
        begin
            file_wr_en_r <= 1'b0;
            cycle_done_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, carry and register port
    // ----------------------------------------------------------------
    // A core update in the same cycle as a software write takes priority,
    // since losing a retired result would corrupt the program flow.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            acc_r <= frd_pkg::ACC_RST;
            carry_r <= frd_pkg::CARRY_RST;
            reg_rdata_r <= 8'h00;
        end
        else
        begin
            acc_r <= acc_nxt;
            carry_r <= carry_nxt;
            // Read data is zero outside the cycle after a read strobe, so a stale value
            // is never mistaken for an answer.
            reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign instr_take = instr_take_r;
    assign file_addr = file_addr_r;
    assign file_rd_en = file_rd_en_r;
    assign file_wr_en = file_wr_en_r;
    assign file_wr_data = file_wr_data_r;
    assign acc_out = acc_r;
    assign carry_out = carry_r;
    assign cycle_done = cycle_done_r;
    assign reg_rdata = reg_rdata_r;

endmodule : frd_datapath

`default_nettype wire

// File: hdl/frd_pkg.sv
`default_nettype none

package frd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int RADDR_W = 3;

    // ----------------------------------------------------------------
    // Instruction word fields
    // ----------------------------------------------------------------
    localparam int CLS_HI = 13;
    localparam int CLS_LO = 12;
    localparam int OP_HI = 11;
    localparam int OP_LO = 8;
    localparam int BOP_HI = 11;
    localparam int BOP_LO = 10;
    localparam int BSEL_HI = 9;
    localparam int BSEL_LO = 7;
    localparam int DSEL_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int FADDR_LO = 0;

    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;

    // Byte-oriented operation codes.
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_STORE_W = 4'h1;
    localparam logic [3:0] OP_CLEAR = 4'h2;
    localparam logic [3:0] OP_MOVE = 4'h3;
    localparam logic [3:0] OP_ROT_LEFT = 4'h4;
    localparam logic [3:0] OP_ROT_RIGHT = 4'h5;
    localparam logic [3:0] OP_INCR = 4'h6;
    localparam logic [3:0] OP_DECR = 4'h7;
    localparam logic [3:0] OP_COMPL = 4'h8;
    localparam logic [3:0] OP_AND_W = 4'h9;
    localparam logic [3:0] OP_OR_W = 4'hA;
    localparam logic [3:0] OP_XOR_W = 4'hB;
    localparam logic [3:0] OP_ADD_W = 4'hC;

    // Bit-oriented operation codes.
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;

    localparam logic [INSTR_W-1:0] INSTR_IDLE = 14'h0000;

    // ----------------------------------------------------------------
    // Register port map and reset values
    // ----------------------------------------------------------------
    localparam logic [RADDR_W-1:0] REG_ACC = 3'h0;
    localparam logic [RADDR_W-1:0] REG_FLAGS = 3'h1;
    localparam logic [RADDR_W-1:0] REG_RESULT = 3'h2;
    localparam logic [RADDR_W-1:0] REG_RETIRED = 3'h3;
    localparam int FLAG_CARRY = 0;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic CARRY_RST = 1'b0;

    // Four-phase instruction cycle, Gray coded.
    typedef enum logic [1:0] {
        FRD_Q1 = 2'b00,
        FRD_Q2 = 2'b01,
        FRD_Q3 = 2'b11,
        FRD_Q4 = 2'b10
    } frd_phase_e;

    // True when the word addresses a file register and so must read it.
    function automatic logic names_file(input logic [INSTR_W-1:0] word);
        logic [1:0] cls;
        logic [3:0] op;
        cls = word[CLS_HI:CLS_LO];
        op = word[OP_HI:OP_LO];
        names_file = 1'b0;
        if (cls == CLS_BYTE)
        begin
            if (op == OP_CLEAR)
                names_file = word[DSEL_BIT];
            else if (op != OP_NOP && op <= OP_ADD_W)
                names_file = 1'b1;
        end
        else if (cls == CLS_BIT)
        begin
            names_file = (word[BOP_HI:BOP_LO] == BOP_CLR) || (word[BOP_HI:BOP_LO] == BOP_SET);
        end
    endfunction : names_file

    function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction : bit_mask

endpackage : frd_pkg

`default_nettype wire

// File: verification/frd_datapath_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checks
// ------
module frd_datapath_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_take,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    input wire logic [7:0] file_rd_data,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data,
    input wire logic [7:0] acc_out,
    input wire logic carry_out,
    input wire logic cycle_done,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_take_rot;
        instr_take && $past(instr_word[13:8]) == 6'h04;
    endsequence
    sequence s_commit;
        ##2 cycle_done;
    endsequence

    property p_rd_take;
        file_rd_en |-> instr_take;
    endproperty
    a_rd_take: assert property (p_rd_take) else $error("read without word");
    property p_wr_rd;
        file_wr_en |-> $past(file_rd_en, 2);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("write without read");
    property p_store_rd;
        instr_take && $past(instr_word[13:8]) == 6'h01 |-> file_rd_en;
    endproperty
    a_store_rd: assert property (p_store_rd) else $error("store skipped read");
    property p_addr;
        instr_take |-> file_addr == $past(instr_word[6:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("wrong file address");
    property p_dest;
        s_take_rot |-> ##2 file_wr_en == $past(instr_word[7], 3);
    endproperty
    a_dest: assert property (p_dest) else $error("wrong destination");
    property p_rot_carry;
        s_take_rot |-> ##2 carry_out == $past(file_rd_data[7]);
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");
    property p_rot_res;
        s_take_rot |-> ##2 (file_wr_en ? file_wr_data : acc_out)
            == {$past(file_rd_data[6:0]), $past(carry_out)};
    endproperty
    a_rot_res: assert property (p_rot_res) else $error("rotate result wrong");
    property p_one_cycle;
        instr_take |-> s_commit;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("late commit");
    property p_period;
        cycle_done |=> !cycle_done [*3] ##1 cycle_done;
    endproperty
    a_period: assert property (p_period) else $error("cycle not four clocks");
    property p_acc_hold;
        file_wr_en && !$past(reg_wr) |-> $stable(acc_out);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("acc moved on file write");
endmodule : frd_datapath_props
`default_nettype wire

// File: verification/frd_file_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// File register model
// ------
module frd_file_model #(
    parameter logic [6:0] PORT_ADDR = 7'h06
) (
    input wire logic clk,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    output logic [7:0] file_rd_data,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data,
    output logic port_change_flag
);
    logic [7:0] mem [0:127];
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 11);
        file_rd_data = 8'h00;
        port_change_flag = 1'b1;
    end
    // Data toggles outside a read so a mistimed sample cannot match by luck.
    always @(posedge clk)
    begin
        if (file_rd_en)
            file_rd_data <= mem[file_addr];
        else
            file_rd_data <= ~file_rd_data;
        if (file_wr_en)
            mem[file_addr] <= file_wr_data;
        if (file_rd_en && file_addr == PORT_ADDR)
            port_change_flag <= 1'b0;
    end
endmodule : frd_file_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] instr_word = 14'h0000;
    logic instr_valid = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic instr_take, file_rd_en, file_wr_en, carry_out, cycle_done, pcf;
    wire logic [6:0] file_addr;
    wire logic [7:0] file_rd_data, file_wr_data, acc_out, reg_rdata;
    logic [7:0] w_exp = 8'h00;
    logic c_exp = 1'b0;
    int miscompares = 0;
    int checks = 0;
    int cyc_exp = 0;
    always #2.5 clk = ~clk;
    frd_datapath frd_datapath_inst (.clk, .sys_rst, .instr_word, .instr_valid, .instr_take,
        .file_addr, .file_rd_en, .file_rd_data, .file_wr_en, .file_wr_data, .acc_out,
        .carry_out, .cycle_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    frd_file_model frd_file_model_inst (.clk, .file_addr, .file_rd_en, .file_rd_data,
        .file_wr_en, .file_wr_data, .port_change_flag(pcf));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    function automatic logic [8:0] calc(input logic [13:0] wd, input logic [7:0] fv,
                                        input logic [7:0] wv, input logic cv);
        logic [7:0] m;
        m = 8'h01 << wd[9:7];
        calc = {cv, fv};
        if (wd[12])
            calc[7:0] = wd[10] ? (fv | m) : (fv & ~m);
        else
            case (wd[11:8])
                4'h1: calc[7:0] = wv;
                4'h2: calc[7:0] = 8'h00;
                4'h4: calc = {fv, cv};
                4'h5: calc = {fv[0], cv, fv[7:1]};
                4'h6: calc[7:0] = fv + 8'h01;
                4'h7: calc[7:0] = fv - 8'h01;
                4'h8: calc[7:0] = ~fv;
                4'h9: calc[7:0] = fv & wv;
                4'hA: calc[7:0] = fv | wv;
                4'hB: calc[7:0] = fv ^ wv;
                4'hC: calc = {1'b0, fv} + {1'b0, wv};
                default: calc = {cv, fv};
            endcase
    endfunction : calc

    // One instruction cycle and one idle cycle, entered on the edge before a Q1 edge.
    task automatic run(input logic [13:0] wd);
        logic [7:0] fv;
        logic [8:0] r;
        logic def;
        logic tof;
        def = wd[13:12] == 2'h0 ? (wd[11:8] != 4'h0 && wd[11:8] <= 4'hC) : wd[13:11] == 3'h2;
        fv = frd_file_model_inst.mem[wd[6:0]];
        r = calc(wd, fv, w_exp, c_exp);
        tof = def && (wd[7] || wd[12] || wd[11:8] == 4'h1);
        instr_word <= wd;
        instr_valid <= 1'b1;
        repeat (4) @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        check("file", frd_file_model_inst.mem[wd[6:0]], tof ? r[7:0] : fv);
        if (def && !tof)
            w_exp = r[7:0];
        if (def)
            c_exp = r[8];
        check("acc", acc_out, w_exp);
        check("carry", {7'h00, carry_out}, {7'h00, c_exp});
        repeat (4) @(posedge clk);
        cyc_exp += 2;
    endtask : run

    // Register access in an idle instruction cycle, so it never meets a core update.
    task automatic rg(input logic wr, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] rexp;
        rexp = a == 3'h0 ? w_exp : a == 3'h1 ? {7'h00, c_exp} : 8'h00;
        if (a == 3'h3)
            rexp = 8'(cyc_exp);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        instr_valid <= 1'b0;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!wr)
            check("reg", reg_rdata, rexp);
        if (wr && a == 3'h0)
            w_exp = d;
        if (wr && a == 3'h1)
            c_exp = d[0];
        repeat (3) @(posedge clk);
        cyc_exp++;
    endtask : rg

    initial
    begin
        void'($urandom(40337));
        repeat (5) @(posedge clk);
        check("acc reset", acc_out, 8'h00);
        sys_rst <= 1'b0;
        run(14'h0286);
        check("change flag", {7'h00, pcf}, 8'h00);
        $display("test clear port done");
        rg(1'b1, 3'h0, 8'hE6);
        run(14'h0190);
        rg(1'b1, 3'h1, 8'h00);
        run(14'h0410);
        check("walk", acc_out, 8'hCC);
        run(14'h0490);
        $display("test rotate done");
        for (int i = 0; i < 16; i++)
            run({2'h0, 4'(i), 8'($urandom)});
        for (int i = 0; i < 32; i++)
            run({2'h1, 5'(i), 7'($urandom)});
        run({2'h2, 12'($urandom)});
        run({2'h3, 12'($urandom)});
        $display("test opcode table done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("acc in reset", acc_out, 8'h00);
        check("carry in reset", {7'h00, carry_out}, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b0;
        w_exp = 8'h00;
        c_exp = 1'b0;
        cyc_exp = 0;
        run(14'h0490);
        $display("test reset done");
        rg(1'b1, 3'h5, 8'h5A);
        for (int a = 0; a < 8; a++)
            rg(1'b0, 3'(a), 8'h00);
        $display("test register port done");
        for (int i = 0; i < 300; i++)
        begin
            if (i % 25 == 0)
                rg(1'b1, 3'($urandom % 2), 8'($urandom));
            run({1'b0, 13'($urandom)});
        end
        $display("test random done");
        conclude();
    end
endmodule : tb

bind frd_datapath frd_datapath_props frd_datapath_props_inst (.clk, .sys_rst, .instr_word,
    .instr_valid, .instr_take, .file_addr, .file_rd_en, .file_rd_data, .file_wr_en,
    .file_wr_data, .acc_out, .carry_out, .cycle_done, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
`default_nettype wire
